// ---- gcc_map.svh ----
// offsets, field positions, reset values and codes of the gate current registers
// assumes a 32-bit apb slave with one aligned word per register index
`ifndef GCC_MAP_SVH
`define GCC_MAP_SVH

// register indices; byte address is four times the index
`define GCC_IDX_LOCK 6'h04
`define GCC_IDX_HS 6'h06
`define GCC_IDX_LS 6'h07
`define GCC_ADDR_LOCK {`GCC_IDX_LOCK, 2'b00}
`define GCC_ADDR_HS {`GCC_IDX_HS, 2'b00}
`define GCC_ADDR_LS {`GCC_IDX_LS, 2'b00}

// reset values
`define GCC_RST_HS 8'hFF
`define GCC_RST_LS 8'hFF
`define GCC_RST_LOCK 3'h3

// field positions inside the gate current registers
`define GCC_SRC_MSB 7
`define GCC_SRC_LSB 4
`define GCC_SNK_MSB 3
`define GCC_SNK_LSB 0

// lock field position and patterns
`define GCC_LOCK_MSB 3
`define GCC_LOCK_LSB 1
`define GCC_PAT_LOCK 3'h6
`define GCC_PAT_UNLOCK 3'h3

`endif

// ---- gcc_pkg.sv ----
// types shared by the gate current register bank
// assumes gcc_map.svh supplies the numeric constants
package gcc_pkg;

  // register selected by an apb address
  typedef enum logic [1:0] {
    GCC_SEL_NONE,
    GCC_SEL_LOCK,
    GCC_SEL_HS,
    GCC_SEL_LS
  } gcc_sel_t;

  // static current codes toward the analog drive stages
  typedef struct packed {
    logic [3:0] hsSourceCurrentCode;
    logic [3:0] hsSinkCurrentCode;
    logic [3:0] lsSourceCurrentCode;
    logic [3:0] lsSinkCurrentCode;
  } gcc_codes_t;

  // whole state of the register bank
  typedef struct packed {
    logic [7:0] highSideGateCurrent;
    logic [7:0] lowSideGateCurrent;
    logic [2:0] lockPat;
    logic [31:0] rdData;
  } gcc_state_t;

endpackage

// ---- gcc_gate_current_regs.sv ----
// gate current configuration registers behind an apb slave
// assumes one clock, synchronous reset and an apb master on the same clock
// limitation: only byte lane 0 carries data, lanes 1 to 3 are dropped
`timescale 1ns/1ps
`include "gcc_map.svh"

// How it works
// - low-side register at index 7, resets FFh
// - bits 7-4 of high-side: source code, reset 1111b
// - bits 3-0 of high-side: sink code, reset 1111b
// - bits 7-4 of low-side: source code, reset 1111b
// - bits 3-0 of low-side: sink code, reset 1111b
// - lock pattern 110b blocks writes, 011b frees them
module gcc_gate_current_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output gcc_pkg::gcc_codes_t codes
);
  import gcc_pkg::*;

  gcc_state_t state_ff;
  gcc_state_t nxt_state;
  gcc_sel_t setupSel;
  gcc_sel_t accessSel;
  logic accessDone;
  logic wrDone;
  logic locked;

  // address decode, shared by setup and access phases
  // unmapped addresses fall through to none, so they never reach state
  function automatic gcc_sel_t decodeSel(input logic [7:0] addr);
    gcc_sel_t sel;
    sel = GCC_SEL_NONE;
    if (addr == `GCC_ADDR_LOCK) begin
      sel = GCC_SEL_LOCK;
    end else if (addr == `GCC_ADDR_HS) begin
      sel = GCC_SEL_HS;
    end else if (addr == `GCC_ADDR_LS) begin
      sel = GCC_SEL_LS;
    end
    return sel;
  endfunction

  // zero wait states; unmapped addresses answer with an error
  assign setupSel = decodeSel(paddr);
  assign accessSel = setupSel;
  // the slave never stretches, but a master must still wait on pready
  assign pready = 1'b1;
  assign pslverr = psel && penable && (accessSel == GCC_SEL_NONE);
  assign accessDone = psel && penable && pready;
  assign wrDone = accessDone && pwrite && pstrb[0] && !pslverr;
  // only two patterns are ever stored, so a compare with one is enough
  assign locked = (state_ff.lockPat == `GCC_PAT_LOCK);

  // next state: writes land at the access edge, read data caught in setup
  always_comb begin
    nxt_state = state_ff;
    if (wrDone) begin
      if (accessSel == GCC_SEL_LOCK) begin
        // patterns other than the two known ones leave the lock alone
        if (pwdata[`GCC_LOCK_MSB:`GCC_LOCK_LSB] == `GCC_PAT_LOCK ||
            pwdata[`GCC_LOCK_MSB:`GCC_LOCK_LSB] == `GCC_PAT_UNLOCK) begin
          nxt_state.lockPat = pwdata[`GCC_LOCK_MSB:`GCC_LOCK_LSB];
        end
      end else if (!locked) begin
        if (accessSel == GCC_SEL_HS) begin
          nxt_state.highSideGateCurrent = pwdata[7:0];
        end else if (accessSel == GCC_SEL_LS) begin
          nxt_state.lowSideGateCurrent = pwdata[7:0];
        end
      end
    end
    // latching in setup keeps prdata a flop output for the access phase
    if (psel && !penable) begin
      nxt_state.rdData = 32'h0000_0000;
      if (setupSel == GCC_SEL_HS) begin
        nxt_state.rdData = {24'h00_0000, state_ff.highSideGateCurrent};
      end else if (setupSel == GCC_SEL_LS) begin
        nxt_state.rdData = {24'h00_0000, state_ff.lowSideGateCurrent};
      end else if (setupSel == GCC_SEL_LOCK) begin
        nxt_state.rdData = {28'h000_0000, state_ff.lockPat, 1'b0};
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff.highSideGateCurrent <= `GCC_RST_HS;
      state_ff.lowSideGateCurrent <= `GCC_RST_LS;
      state_ff.lockPat <= `GCC_RST_LOCK;
      // read data cleared too, so nothing stale shows after reset
      state_ff.rdData <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // codes come straight from the flops, so the analog side never sees glitches
  assign prdata = state_ff.rdData;
  assign codes.hsSourceCurrentCode = state_ff.highSideGateCurrent[`GCC_SRC_MSB:`GCC_SRC_LSB];
  assign codes.hsSinkCurrentCode = state_ff.highSideGateCurrent[`GCC_SNK_MSB:`GCC_SNK_LSB];
  assign codes.lsSourceCurrentCode = state_ff.lowSideGateCurrent[`GCC_SRC_MSB:`GCC_SRC_LSB];
  assign codes.lsSinkCurrentCode = state_ff.lowSideGateCurrent[`GCC_SNK_MSB:`GCC_SNK_LSB];

  // checks on the design's own outputs and on its internal lock state
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  lsReset_a: assert property (disable iff (1'b0) rst |=> codes.lsSourceCurrentCode == 4'hF && codes.lsSinkCurrentCode == 4'hF)
    else $error("low-side codes not at reset value");
  hsReset_a: assert property (disable iff (1'b0) rst |=> codes.hsSourceCurrentCode == 4'hF && codes.hsSinkCurrentCode == 4'hF)
    else $error("high-side codes not at reset value");
  hsSinkWrite_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h18 && !locked
    |=> codes.hsSinkCurrentCode == $past(pwdata[3:0]) && codes.hsSourceCurrentCode == $past(pwdata[7:4]))
    else $error("high-side write did not reach codes");
  lsSourceWrite_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h1C && !locked
    |=> codes.lsSourceCurrentCode == $past(pwdata[7:4]))
    else $error("low-side source code not written");
  lsSinkWrite_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h1C && !locked
    |=> codes.lsSinkCurrentCode == $past(pwdata[3:0]))
    else $error("low-side sink code not written");
  lockedWrite_a: assert property (locked && !(psel && penable && pwrite && paddr == 8'h10)
    |=> $stable(codes))
    else $error("codes changed while locked");
  lockSet_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h10 && pwdata[3:1] == 3'h6
    |=> locked ##1 locked || !(psel && penable && pwrite))
    else $error("lock pattern did not lock");
  readBack_a: assert property (psel && !penable && !pwrite && paddr == 8'h1C
    ##1 psel && penable |-> prdata == {24'h00_0000, codes.lsSourceCurrentCode, codes.lsSinkCurrentCode})
    else $error("low-side read data differs from register");

  // further checks on reads, writes, error responses, reset and the lock
  // those that name a register compare against fixed addresses, not the decoder

  // high-side read returns the register in the access phase
  hsReadBack_a: assert property (psel && !penable && !pwrite && paddr == 8'h18
    ##1 psel && penable |-> prdata == {24'h00_0000, codes.hsSourceCurrentCode, codes.hsSinkCurrentCode})
    else $error("high-side read data differs from register");

  // lock register reads back its stored pattern
  lockRead_a: assert property (psel && !penable && !pwrite && paddr == 8'h10
    ##1 psel && penable |-> prdata == (locked ? 32'h0000_000C : 32'h0000_0006))
    else $error("lock read data differs from pattern");

  // reset always leaves the registers writable
  lockReset_a: assert property (disable iff (1'b0)
    rst |=> !locked)
    else $error("lock not released by reset");

  // no stale read data right after reset
  readReset_a: assert property (disable iff (1'b0)
    rst |=> prdata == 32'h0000_0000)
    else $error("read data not cleared by reset");

  // read data only moves at a setup edge
  readIdle_a: assert property (!(psel && !penable)
    |=> $stable(prdata))
    else $error("read data moved outside setup");

  // codes are static between writes
  // a glitch here would reach the analog current selectors
  codesQuiet_a: assert property (!(psel && penable && pwrite)
    |=> $stable(codes))
    else $error("codes changed without a write");

  // a write without lane 0 leaves the codes alone
  strobeDrop_a: assert property (psel && penable && pwrite && !pstrb[0]
    |=> $stable(codes))
    else $error("codes changed on a write without lane 0");

  // a low-side write never touches the high-side codes
  lsOnly_a: assert property (psel && penable && pwrite && paddr == 8'h1C
    |=> $stable(codes.hsSourceCurrentCode) && $stable(codes.hsSinkCurrentCode))
    else $error("low-side write changed high-side codes");

  // a high-side write never touches the low-side codes
  hsOnly_a: assert property (psel && penable && pwrite && paddr == 8'h18
    |=> $stable(codes.lsSourceCurrentCode) && $stable(codes.lsSinkCurrentCode))
    else $error("high-side write changed low-side codes");

  // the unlock pattern frees the registers at once
  unlockWrite_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h10 && pwdata[3:1] == 3'h3
    |=> !locked)
    else $error("unlock pattern did not unlock");

  // patterns other than unlock keep the lock in place
  lockHold_a: assert property (locked && psel && penable && pwrite && paddr == 8'h10 && pwdata[3:1] != 3'h3
    |=> locked)
    else $error("lock dropped by other pattern");

  // a locked write is dropped silently, with no error
  lockedNoErr_a: assert property (locked && psel && penable && pwrite && (paddr == 8'h18 || paddr == 8'h1C)
    |-> !pslverr)
    else $error("locked write answered with an error");

  // mapped registers never answer with an error
  mappedNoErr_a: assert property (psel && penable && (paddr == 8'h10 || paddr == 8'h18 || paddr == 8'h1C)
    |-> !pslverr)
    else $error("mapped register answered with an error");

  // every other address answers with an error
  unmappedErr_a: assert property (psel && penable && paddr != 8'h10 && paddr != 8'h18 && paddr != 8'h1C
    |-> pslverr)
    else $error("unmapped address answered without error");

  lockedWriteTry_c: cover property (locked && psel && penable && pwrite && paddr == 8'h18);
  unlockAgain_c: cover property (locked ##[1:40] !locked);
  lsReadBack_c: cover property (psel && penable && !pwrite && paddr == 8'h1C && prdata[7:0] != 8'hFF);
  // write with lane 0 off
  strobeDrop_c: cover property (psel && penable && pwrite && !pstrb[0] && paddr == 8'h1C);
endmodule

// ---- gcc_gate_current_regs_tb.sv ----
// self-checking bench for the gate current register bank
// assumes the design and its map header are compiled first
`timescale 1ns/1ps
`include "gcc_map.svh"
module gcc_gate_current_regs_tb;
  import gcc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  gcc_codes_t codes;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  gcc_gate_current_regs i_gcc_gate_current_regs (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .codes(codes));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hF);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(what, rd, exp);
  endtask
  task automatic t_reset();
    @(posedge clk); // let the reset edge land before looking
    chk("codes", codes, 32'hFFFF);
    chk("pready", {31'h0, pready}, 32'h1);
    rdchk("hs", `GCC_ADDR_HS, 32'hFF);
    chk("slverr mapped", {31'h0, err}, 32'h0);
    rdchk("ls", `GCC_ADDR_LS, 32'hFF);
    rdchk("lock", `GCC_ADDR_LOCK, 32'h6);
  endtask
  // every code in every field; codes read after a later transfer so they have settled
  task automatic t_rw();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      wr(`GCC_ADDR_HS, {k, ~k});
      wr(`GCC_ADDR_LS, {~k, k});
      rdchk("hs", `GCC_ADDR_HS, {24'h0, k, ~k});
      chk("codes", codes, {16'h0, k, ~k, ~k, k});
    end
  endtask
  task automatic t_refuse();
    apb(1'b1, `GCC_ADDR_LS, 32'h12, 4'hE);
    rdchk("ls strb", `GCC_ADDR_LS, 32'h0F);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
  endtask
  task automatic t_lock();
    wr(`GCC_ADDR_LOCK, 8'h0C);
    rdchk("lock set", `GCC_ADDR_LOCK, 32'hC);
    wr(`GCC_ADDR_LOCK, 8'h0A);
    rdchk("lock kept", `GCC_ADDR_LOCK, 32'hC);
    wr(`GCC_ADDR_LS, 8'h33);
    wr(`GCC_ADDR_HS, 8'h44);
    rdchk("ls locked", `GCC_ADDR_LS, 32'h0F);
    rdchk("hs locked", `GCC_ADDR_HS, 32'hF0);
    wr(`GCC_ADDR_LOCK, 8'h06);
    wr(`GCC_ADDR_LS, 8'h33);
    rdchk("ls free", `GCC_ADDR_LS, 32'h33);
    chk("codes", codes, 32'hF033);
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // second reset in mid-run must restore values and unlock
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_refuse();
    t_lock();
    wr(`GCC_ADDR_LOCK, 8'h0C);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    t_reset();
    conclude();
  end
endmodule
